// file: core/ufs_map.svh
// Register offsets, field positions, reset values and timing counts of the USB FIFO/status block.
// Assumes an 8-bit register space addressed by the CPU core's special-function register port.
`ifndef UFS_MAP_SVH
`define UFS_MAP_SVH

`define UFS_OFF_FIFO0_DATA 8'hA6
`define UFS_OFF_FIFO1_PTR 8'hA7
`define UFS_OFF_FIFO1_DATA 8'hA8
`define UFS_OFF_BUS_STATUS 8'hA9
`define UFS_OFF_STALL_DRIVE 8'hAA

`define UFS_STAT_COUNT_LSB 0
`define UFS_STAT_COUNT_MSB 4
`define UFS_STAT_BUSRST_BIT 5
`define UFS_STAT_SUSPEND_BIT 6
`define UFS_STAT_SWAP_BIT 7

`define UFS_DRV_DMINUS_BIT 0
`define UFS_DRV_DPLUS_BIT 1
`define UFS_DRV_ENABLE_BIT 2
`define UFS_DRV_STALL_LSB 3
`define UFS_DRV_STALL_MSB 6

`define UFS_RST_BYTE 8'h00
`define UFS_RST_PTR 5'h00
`define UFS_RST_COUNT 5'h00
`define UFS_RST_DRIVE 7'h00

`define UFS_RESUME_INSTR 8
`define UFS_FIFO_BYTES 32
`define UFS_EP_COUNT 4

`endif

// file: core/ufs_pkg.sv
// Types shared by the USB FIFO/status block and its surroundings.
// Assumes the constant header is on the include path.
`include "ufs_map.svh"

package ufs_pkg;

    typedef enum logic [1:0] {
        UFS_HS_NONE,
        UFS_HS_ACK,
        UFS_HS_NAK,
        UFS_HS_STALL
    } ufs_hs_t;

    // One received OUT data byte from the serial engine.
    typedef struct packed {
        logic valid;
        logic [1:0] ep;
        logic [2:0] idx;
        logic [7:0] data;
    } ufs_rx_t;

    // An IN token, or an IN byte fetch, addressed to one endpoint.
    typedef struct packed {
        logic valid;
        logic [1:0] ep;
        logic [2:0] idx;
    } ufs_req_t;

    typedef struct packed {
        logic [`UFS_FIFO_BYTES-1:0][7:0] fifo0;
        logic [`UFS_FIFO_BYTES-1:0][7:0] fifo1;
        logic [4:0] ptr1;
        logic [4:0] outCnt;
        logic busRst;
        logic suspend;
        logic [3:0] resumeCnt;
        logic [6:0] drive;
        logic [7:0] rdData;
        logic [7:0] txData;
        ufs_hs_t hsResp;
        logic hsValid;
        logic setNotReady;
        logic [1:0] notReadyEp;
        logic setOutDone;
        logic [1:0] outDoneEp;
    } ufs_state_t;

endpackage

// file: core/usb_fifo_status_and_bus_drive.sv
// USB low-speed device function, firmware side: two FIFOs with pointer/data ports, status and line drive.
// Assumes a serial engine delivers OUT bytes, IN tokens and IN byte fetches synchronous to clk.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

`include "ufs_map.svh"

module usb_fifo_status_and_bus_drive #(
    parameter int CLK_PER_INSTR = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [4:0] fifo0Ptr,
    input wire logic ep0BufferSwap,
    input wire logic [3:1] epBufferSwap,
    input wire logic [3:0] epInNotReady,
    input wire logic busResetDet,
    input wire logic suspendReq,
    input wire logic resumeWake,
    input wire ufs_pkg::ufs_rx_t rxIn,
    input wire logic outRxDone,
    input wire logic [1:0] outRxEp,
    input wire ufs_pkg::ufs_req_t inToken,
    input wire ufs_pkg::ufs_req_t txFetch,
    output logic [7:0] txData,
    output ufs_pkg::ufs_hs_t hsResp,
    output logic hsValid,
    output logic setInNotReady,
    output logic [1:0] setInNotReadyEp,
    output logic setOutDone,
    output logic [1:0] setOutDoneEp,
    output logic lineDriveOe,
    output logic dplusOut,
    output logic dminusOut
);
    import ufs_pkg::*;

    localparam logic [3:0] RESUME_COUNT = 4'(`UFS_RESUME_INSTR * CLK_PER_INSTR);

    ufs_state_t st_r;
    ufs_state_t st_nxt;
    logic [3:0] swapAll;
    logic [3:0] forceStall;
    logic [4:0] rxAddr;
    logic [4:0] txAddr;
    logic fwWrFifo0;
    logic fwWrFifo1;
    logic fwWrStatus;

    // ============================================================
    // Address decode and buffer selection
    // ============================================================
    assign swapAll = {epBufferSwap, ep0BufferSwap};
    assign forceStall = st_r.drive[`UFS_DRV_STALL_MSB:`UFS_DRV_STALL_LSB];
    assign rxAddr = {rxIn.ep, rxIn.idx};
    assign txAddr = {txFetch.ep, txFetch.idx};
    assign fwWrFifo0 = regWr && (regAddr == `UFS_OFF_FIFO0_DATA);
    assign fwWrFifo1 = regWr && (regAddr == `UFS_OFF_FIFO1_DATA);
    assign fwWrStatus = regWr && (regAddr == `UFS_OFF_BUS_STATUS);

    // ============================================================
    // Next-state logic
    // ============================================================
    always_comb begin
        st_nxt = st_r;
        st_nxt.hsValid = 1'b0;
        st_nxt.hsResp = UFS_HS_NONE;
        st_nxt.setNotReady = 1'b0;
        st_nxt.setOutDone = 1'b0;
        st_nxt.rdData = `UFS_RST_BYTE;

        // Firmware port writes use the pointers as they stand.
        if (fwWrFifo0) begin
            st_nxt.fifo0[fifo0Ptr] = regWrData;
        end
        if (fwWrFifo1) begin
            st_nxt.fifo1[st_r.ptr1] = regWrData;
        end
        if (regWr && (regAddr == `UFS_OFF_FIFO1_PTR)) begin
            st_nxt.ptr1 = regWrData[4:0];
        end
        if (regWr && (regAddr == `UFS_OFF_STALL_DRIVE)) begin
            st_nxt.drive = regWrData[6:0];
        end
        if (fwWrStatus) begin
            st_nxt.outCnt = regWrData[`UFS_STAT_COUNT_MSB:`UFS_STAT_COUNT_LSB];
        end

        // An OUT byte lands in the FIFO that holds this endpoint's OUT data and wins over firmware.
        if (rxIn.valid) begin
            if (swapAll[rxIn.ep]) begin
                st_nxt.fifo0[rxAddr] = rxIn.data;
            end else begin
                st_nxt.fifo1[rxAddr] = rxIn.data;
            end
            if (rxIn.ep == 2'h0) begin
                st_nxt.outCnt = st_nxt.outCnt + 5'h01;
            end
        end

        // IN data comes from the other FIFO of the pair.
        if (txFetch.valid) begin
            st_nxt.txData = swapAll[txFetch.ep] ? st_r.fifo1[txAddr] : st_r.fifo0[txAddr];
        end

        if (inToken.valid) begin
            st_nxt.hsValid = 1'b1;
            if (epInNotReady[inToken.ep] && forceStall[inToken.ep]) begin
                st_nxt.hsResp = UFS_HS_STALL;
            end else if (epInNotReady[inToken.ep]) begin
                st_nxt.hsResp = UFS_HS_NAK;
            end else begin
                st_nxt.hsResp = UFS_HS_ACK;
                st_nxt.setNotReady = 1'b1;
                st_nxt.notReadyEp = inToken.ep;
            end
        end

        if (outRxDone) begin
            st_nxt.setOutDone = 1'b1;
            st_nxt.outDoneEp = outRxEp;
        end

        st_nxt.busRst = busResetDet;

        // Suspend request wins over a running resume count.
        if (suspendReq) begin
            st_nxt.suspend = 1'b1;
            st_nxt.resumeCnt = 4'h0;
        end else if (resumeWake && st_r.suspend && (st_r.resumeCnt == 4'h0)) begin
            st_nxt.resumeCnt = RESUME_COUNT;
        end else if (st_r.resumeCnt != 4'h0) begin
            st_nxt.resumeCnt = st_r.resumeCnt - 4'h1;
            if (st_r.resumeCnt == 4'h1) begin
                st_nxt.suspend = 1'b0;
            end
        end

        if (regRd) begin
            case (regAddr)
                `UFS_OFF_FIFO0_DATA: st_nxt.rdData = st_r.fifo0[fifo0Ptr];
                `UFS_OFF_FIFO1_PTR: st_nxt.rdData = {3'h0, st_r.ptr1};
                `UFS_OFF_FIFO1_DATA: st_nxt.rdData = st_r.fifo1[st_r.ptr1];
                `UFS_OFF_BUS_STATUS: st_nxt.rdData = {ep0BufferSwap, st_r.suspend, st_r.busRst, st_r.outCnt};
                default: st_nxt.rdData = `UFS_RST_BYTE;
            endcase
        end
    end

    // ============================================================
    // State register
    // ============================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign txData = st_r.txData;
    assign hsResp = st_r.hsResp;
    assign hsValid = st_r.hsValid;
    assign setInNotReady = st_r.setNotReady;
    assign setInNotReadyEp = st_r.notReadyEp;
    assign setOutDone = st_r.setOutDone;
    assign setOutDoneEp = st_r.outDoneEp;
    assign lineDriveOe = st_r.drive[`UFS_DRV_ENABLE_BIT];
    assign dplusOut = st_r.drive[`UFS_DRV_DPLUS_BIT];
    assign dminusOut = st_r.drive[`UFS_DRV_DMINUS_BIT];

    // ============================================================
    // Assertions
    // ============================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    ptr1Readback_a: assert property (
        clkEn && regWr && regAddr == `UFS_OFF_FIFO1_PTR ##1 clkEn && regRd && regAddr == `UFS_OFF_FIFO1_PTR
        |=> regRdData == {3'h0, $past(regWrData[4:0], 2)}
    ) else $error("pointer 1 readback differs from written value");

    fifo1Port_a: assert property (
        clkEn && fwWrFifo1 && !rxIn.valid |=> st_r.fifo1[$past(st_r.ptr1)] == $past(regWrData)
    ) else $error("FIFO 1 port write missed its byte");

    fifo0Read_a: assert property (
        clkEn && regRd && regAddr == `UFS_OFF_FIFO0_DATA |=> regRdData == $past(st_r.fifo0[fifo0Ptr])
    ) else $error("FIFO 0 port read wrong byte");

    outRoute_a: assert property (
        clkEn && rxIn.valid |=> ($past(swapAll[rxIn.ep]) ? st_r.fifo0[$past(rxAddr)] : st_r.fifo1[$past(rxAddr)])
            == $past(rxIn.data)
    ) else $error("OUT byte stored in wrong FIFO");

    outCount_a: assert property (
        clkEn && rxIn.valid && rxIn.ep == 2'h0 && !fwWrStatus |=> st_r.outCnt == $past(st_r.outCnt) + 5'h01
    ) else $error("endpoint 0 OUT byte count did not advance");

    busReset_a: assert property (
        clkEn |=> st_r.busRst == $past(busResetDet)
    ) else $error("bus reset flag does not follow detection");

    suspendSet_a: assert property (
        clkEn && suspendReq |=> st_r.suspend && st_r.resumeCnt == 4'h0
    ) else $error("suspend request not flagged");

    resumeEarly_a: assert property (
        (clkEn && resumeWake && st_r.suspend && st_r.resumeCnt == 4'h0 && !suspendReq)
        ##1 (clkEn && !suspendReq)[*7] |-> st_r.suspend
    ) else $error("suspend flag cleared too early");

    resumeClear_a: assert property (
        (clkEn && resumeWake && st_r.suspend && st_r.resumeCnt == 4'h0 && !suspendReq)
        ##1 (clkEn && !suspendReq)[*8] |=> !st_r.suspend
    ) else $error("suspend flag not cleared after resume");

    stallAnswer_a: assert property (
        clkEn && inToken.valid |=> hsValid && (hsResp == UFS_HS_STALL) ==
            ($past(epInNotReady[inToken.ep]) && $past(forceStall[inToken.ep]))
    ) else $error("STALL answer does not match stall and not-ready bits");

    ackThenBusy_a: assert property (
        clkEn && inToken.valid && !epInNotReady[inToken.ep]
        |=> hsResp == UFS_HS_ACK && setInNotReady && setInNotReadyEp == $past(inToken.ep)
    ) else $error("ready endpoint not acknowledged and marked busy");

    outDone_a: assert property (
        clkEn && outRxDone |=> setOutDone && setOutDoneEp == $past(outRxEp)
    ) else $error("OUT-done not signalled");

    lineDrive_a: assert property (
        clkEn && regWr && regAddr == `UFS_OFF_STALL_DRIVE
        |=> lineDriveOe == $past(regWrData[2]) && dplusOut == $past(regWrData[1]) && dminusOut == $past(regWrData[0])
    ) else $error("line drive bits not applied");

    // ============================================================
    // Register port checks
    // ============================================================
    ptr1Write_a: assert property (
        clkEn && regWr && regAddr == `UFS_OFF_FIFO1_PTR |=> st_r.ptr1 == $past(regWrData[4:0])
    ) else $error("pointer 1 write not taken");

    fifo0Port_a: assert property (
        clkEn && fwWrFifo0 && !rxIn.valid |=> st_r.fifo0[$past(fifo0Ptr)] == $past(regWrData)
    ) else $error("FIFO 0 port write missed its byte");

    fifo1Read_a: assert property (
        clkEn && regRd && regAddr == `UFS_OFF_FIFO1_DATA |=> regRdData == $past(st_r.fifo1[st_r.ptr1])
    ) else $error("FIFO 1 port read wrong byte");

    statusRead_a: assert property (
        clkEn && regRd && regAddr == `UFS_OFF_BUS_STATUS
        |=> regRdData == $past({ep0BufferSwap, st_r.suspend, st_r.busRst, st_r.outCnt})
    ) else $error("status read does not show its fields");

    writeOnlyRead_a: assert property (
        clkEn && regRd && regAddr == `UFS_OFF_STALL_DRIVE |=> regRdData == `UFS_RST_BYTE
    ) else $error("write-only drive register did not read zero");

    readIdle_a: assert property (
        clkEn && !regRd |=> regRdData == `UFS_RST_BYTE
    ) else $error("read data stands without a read");

    unmappedRead_a: assert property (
        clkEn && regRd && !(regAddr inside {[`UFS_OFF_FIFO0_DATA:`UFS_OFF_STALL_DRIVE]})
        |=> regRdData == `UFS_RST_BYTE
    ) else $error("unmapped address did not read zero");

    ptrHold_a: assert property (
        clkEn && !(regWr && regAddr == `UFS_OFF_FIFO1_PTR) |=> $stable(st_r.ptr1)
    ) else $error("pointer 1 moved without a write");

    // A frozen clock enable must keep every bit of state.
    stateFreeze_a: assert property (
        !clkEn |=> $stable(st_r)
    ) else $error("state changed while clock enable was low");

    // ============================================================
    // Link-side checks
    // ============================================================
    ep0Window_a: assert property (
        clkEn && rxIn.valid && rxIn.ep == 2'h0 |-> rxAddr inside {[5'h00:5'h07]}
    ) else $error("endpoint 0 byte outside its window");

    ep1Window_a: assert property (
        clkEn && rxIn.valid && rxIn.ep == 2'h1 |-> rxAddr inside {[5'h08:5'h0F]}
    ) else $error("endpoint 1 byte outside its window");

    ep2Window_a: assert property (
        clkEn && rxIn.valid && rxIn.ep == 2'h2 |-> rxAddr inside {[5'h10:5'h17]}
    ) else $error("endpoint 2 byte outside its window");

    ep3Window_a: assert property (
        clkEn && rxIn.valid && rxIn.ep == 2'h3 |-> rxAddr inside {[5'h18:5'h1F]}
    ) else $error("endpoint 3 byte outside its window");

    outCountWrite_a: assert property (
        clkEn && fwWrStatus && !(rxIn.valid && rxIn.ep == 2'h0) |=> st_r.outCnt == $past(regWrData[4:0])
    ) else $error("OUT byte count write not taken");

    outCountHold_a: assert property (
        clkEn && !fwWrStatus && !(rxIn.valid && rxIn.ep == 2'h0) |=> $stable(st_r.outCnt)
    ) else $error("OUT byte count moved with no byte");

    fetchRoute_a: assert property (
        clkEn && txFetch.valid
        |=> txData == $past(swapAll[txFetch.ep] ? st_r.fifo1[txAddr] : st_r.fifo0[txAddr])
    ) else $error("IN byte fetched from wrong FIFO");

    fetchHold_a: assert property (
        clkEn && !txFetch.valid |=> $stable(txData)
    ) else $error("IN byte changed without a fetch");

    nakAnswer_a: assert property (
        clkEn && inToken.valid && epInNotReady[inToken.ep] && !forceStall[inToken.ep]
        |=> hsValid && hsResp == UFS_HS_NAK && !setInNotReady
    ) else $error("not-ready endpoint not answered with NAK");

    stallOthers_a: assert property (
        clkEn && inToken.valid && inToken.ep != 2'h0 && epInNotReady[inToken.ep] && forceStall[inToken.ep]
        |=> hsValid && hsResp == UFS_HS_STALL && !setInNotReady
    ) else $error("stalled endpoint 1 to 3 not answered with STALL");

    hsQuiet_a: assert property (
        clkEn && !inToken.valid |=> !hsValid && hsResp == UFS_HS_NONE && !setInNotReady
    ) else $error("handshake given without a token");

    outDoneQuiet_a: assert property (
        clkEn && !outRxDone |=> !setOutDone
    ) else $error("OUT-done signalled without a packet end");

    // ============================================================
    // Status checks
    // ============================================================
    suspendRise_a: assert property (
        clkEn && !suspendReq |=> !$rose(st_r.suspend)
    ) else $error("suspend flag rose without a request");

    resumeSeen_c: cover property (st_r.suspend ##[1:20] !st_r.suspend);
    stallSeen_c: cover property (hsValid && hsResp == UFS_HS_STALL);
    ackSeen_c: cover property (hsValid && hsResp == UFS_HS_ACK);
    portRoundTrip_c: cover property (clkEn && fwWrFifo1 ##1 clkEn && regRd && regAddr == `UFS_OFF_FIFO1_DATA);
    freezeSeen_c: cover property (!clkEn && regWr);

endmodule

// file: testbench/ufs_host_model.sv
// Cable-side partner of the USB FIFO block: OUT bytes, IN tokens and IN byte fetches.
// Assumes its tasks are called right after a rising edge of clk.
`timescale 1ns/1ps
module ufs_host_model (
    input wire logic clk,
    output ufs_pkg::ufs_rx_t rxIn,
    output logic outRxDone,
    output logic [1:0] outRxEp,
    output ufs_pkg::ufs_req_t inToken,
    output ufs_pkg::ufs_req_t txFetch
);
    import ufs_pkg::*;
    // ======================================
    // Transfers
    // Released fields carry the inverse of their last value, so stale data never looks valid.
    initial begin
        rxIn = '0;
        outRxDone = 1'b0;
        outRxEp = 2'h0;
        inToken = '0;
        txFetch = '0;
    end
    task automatic sendOut(input logic [1:0] ep, input logic [2:0] idx, input logic [7:0] d);
        rxIn <= '{1'b1, ep, idx, d};
        @(posedge clk);
        rxIn <= '{1'b0, ~ep, ~idx, ~d};
        outRxDone <= 1'b1;
        outRxEp <= ep;
        @(posedge clk);
        outRxDone <= 1'b0;
        outRxEp <= ~ep;
    endtask
    task automatic token(input logic [1:0] ep);
        inToken <= '{1'b1, ep, 3'h0};
        @(posedge clk);
        inToken <= '{1'b0, ~ep, 3'h7};
    endtask
    task automatic fetch(input logic [1:0] ep, input logic [2:0] idx);
        txFetch <= '{1'b1, ep, idx};
        @(posedge clk);
        txFetch <= '{1'b0, ~ep, ~idx};
    endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench of the USB FIFO, status and line-drive block.
// Assumes the host model stands on the cable side; clkEn is held high except for one frozen pointer write.
`timescale 1ns/1ps
module tb;
    import ufs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [4:0] fifo0Ptr = 5'h00;
    logic ep0BufferSwap = 1'b0;
    logic [3:1] epBufferSwap = 3'h0;
    logic [3:0] epInNotReady = 4'h0;
    logic busResetDet = 1'b0;
    logic suspendReq = 1'b0;
    logic resumeWake = 1'b0;
    ufs_rx_t rxIn;
    ufs_req_t inToken;
    ufs_req_t txFetch;
    ufs_hs_t hsResp;
    logic outRxDone, hsValid, sinr, sod, oe, dp, dm, s;
    logic [1:0] outRxEp, sodEp, doneEp;
    logic [7:0] txData, d, dOut;
    logic [4:0] p;
    logic clkEn = 1'b1;
    logic [1:0] sinrEp;
    logic rdPend = 1'b0;
    logic fetchPend = 1'b0;
    logic outPend = 1'b0;
    logic [7:0] expQ[$];
    logic [4:0] hsQ[$];
    int num_errors = 0;
    int total_checks = 0;
    int seed = 8;
    always #12.5 clk = ~clk;
    ufs_host_model host (.clk(clk), .rxIn(rxIn), .outRxDone(outRxDone), .outRxEp(outRxEp),
        .inToken(inToken), .txFetch(txFetch));
    usb_fifo_status_and_bus_drive uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .fifo0Ptr(fifo0Ptr),
        .ep0BufferSwap(ep0BufferSwap), .epBufferSwap(epBufferSwap), .epInNotReady(epInNotReady),
        .busResetDet(busResetDet), .suspendReq(suspendReq), .resumeWake(resumeWake), .rxIn(rxIn),
        .outRxDone(outRxDone), .outRxEp(outRxEp), .inToken(inToken), .txFetch(txFetch), .txData(txData),
        .hsResp(hsResp), .hsValid(hsValid), .setInNotReady(sinr), .setInNotReadyEp(sinrEp),
        .setOutDone(sod), .setOutDoneEp(sodEp), .lineDriveOe(oe), .dplusOut(dp), .dminusOut(dm));
    // ======================================
    // Tasks
    task automatic conclude;
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes stay up until the next bus task or idle, so back-to-back cycles never reassign them in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        regWr <= 1'b1;
        regRd <= 1'b0;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regRd <= 1'b1;
        regWr <= 1'b0;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
    endtask
    task automatic idle;
        regWr <= 1'b0;
        regRd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setPtr(input logic f, input logic [4:0] v);
        if (f) wr(8'hA7, {3'h0, v});
        else fifo0Ptr <= v;
    endtask
    // ======================================
    // Result monitor
    always @(posedge clk) begin
        if (rdPend || fetchPend) chk(rdPend ? regRdData : txData, expQ.pop_front());
        if (hsValid) chk({3'h0, sinrEp, sinr, hsResp}, {3'h0, hsQ.pop_front()});
        if (outPend) chk({5'h0, sod, sodEp}, {5'h0, 1'b1, doneEp});
        rdPend <= regRd;
        fetchPend <= txFetch.valid;
        outPend <= outRxDone;
        doneEp <= outRxEp;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        conclude();
    end
    // ======================================
    // Scenarios
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int a = 8'hA6; a <= 8'hAA; a++) rd(a[7:0], 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        wr(8'hA7, 8'hFF);
        rd(8'hA7, 8'h1F);
        clkEn <= 1'b0;
        wr(8'hA7, 8'h03);
        clkEn <= 1'b1;
        rd(8'hA7, 8'h1F);
        for (int i = 0; i < 6; i++) begin
            p = 5'($random(seed));
            d = 8'($random(seed));
            setPtr(i[0], p);
            wr(i[0] ? 8'hA8 : 8'hA6, d);
            rd(i[0] ? 8'hA8 : 8'hA6, d);
            rd(i[0] ? 8'hA8 : 8'hA6, d);
        end
        wr(8'hA9, 8'hEA);
        for (int ep = 0; ep < 4; ep++) begin
            s = ep[0];
            {epBufferSwap, ep0BufferSwap} <= {4{s}};
            p = {ep[1:0], 3'($random(seed))};
            d = 8'($random(seed));
            dOut = 8'($random(seed));
            setPtr(s, p);
            wr(s ? 8'hA8 : 8'hA6, d);
            idle();
            host.sendOut(ep[1:0], p[2:0], dOut);
            setPtr(!s, p);
            rd(s ? 8'hA6 : 8'hA8, dOut);
            idle();
            expQ.push_back(d);
            host.fetch(ep[1:0], p[2:0]);
        end
        rd(8'hA9, 8'h8B);
        for (int ep = 0; ep < 4; ep++) begin
            for (int k = 0; k < 4; k++) begin
                wr(8'hAA, {1'b0, k[0] ? (4'h1 << ep) : 4'h0, 3'h0});
                epInNotReady <= k[1] ? (4'h1 << ep) : 4'h0;
                idle();
                hsQ.push_back({ep[1:0], !k[1], k[1] ? (k[0] ? UFS_HS_STALL : UFS_HS_NAK) : UFS_HS_ACK});
                host.token(ep[1:0]);
            end
        end
        for (int k = 0; k < 8; k++) begin
            wr(8'hAA, {1'b0, 4'($random(seed)), k[2:0]});
            idle();
            chk({5'h0, oe, dp, dm}, {5'h0, k[2:0]});
        end
        rd(8'hAA, 8'h00);
        busResetDet <= 1'b1;
        idle();
        idle();
        rd(8'hA9, 8'hAB);
        busResetDet <= 1'b0;
        idle();
        idle();
        rd(8'hA9, 8'h8B);
        suspendReq <= 1'b1;
        idle();
        suspendReq <= 1'b0;
        idle();
        rd(8'hA9, 8'hCB);
        idle();
        resumeWake <= 1'b1;
        @(posedge clk);
        resumeWake <= 1'b0;
        repeat (7) @(posedge clk);
        rd(8'hA9, 8'hCB);
        idle();
        rd(8'hA9, 8'h8B);
        idle();
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule
